// File: test_wtc_regs.sv
// Self-checking testbench of the waveform timer register bank
module test_wtc_regs
  import wtc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct packed {
    logic [5:0] idx;
    logic [31:0] wd;
    logic [31:0] ex;
  } wtc_row_t;

  // Stimulus and observed signals
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic ce_i = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic trig_a_i = 1'b0;
  logic trig_b_i = 1'b0;
  logic fast_osc_tick_i = 1'b0;
  logic pll_tick_i = 1'b0;
  logic ext_clk_i = 1'b0;
  logic [2:0] tick_cnt = 3'h0;
  logic debug_halt_i = 1'b0;
  logic key_written_i = 1'b0;
  logic irq_o;
  logic [1:0] core_clk_sel_o;
  logic timer_run_o;
  logic [11:0] count_o;
  logic prog_event_o;
  logic fault_a_o;
  logic fault_b_o;
  int err_count = 0;
  int n_checks = 0;

  // Ordinary cases: write a value, read back the masked value
  wtc_row_t rows [10] = '{
    '{IDX_CLK_EN_CTRL, 32'h7E, 32'h7E},
    '{IDX_WAVE_MODE, 32'hFF, 32'h03},
    '{IDX_OUT_SEL, 32'hFF, 32'hCB},
    '{IDX_DIT_VAL, 32'hFF, 32'h0F},
    '{IDX_DBG_CTRL, 32'hFF, 32'h05},
    '{IDX_IRQ_EN, 32'hFF, 32'h0D},
    '{IDX_DLY_CNT, 32'hFF, 32'hFF},
    '{IDX_CMP_B_CLR, 32'hFFFF, 32'h0FFF},
    '{6'h05, 32'hFF, 32'h00},
    '{IDX_CAP_A, 32'hFFFF, 32'h0000}
  };
  logic [31:0] cexp [4] = '{32'h40, 32'h10, 32'h02, 32'h00};
  logic [31:0] sexp [3] = '{32'h20, 32'h10, 32'h08};

  always #10 clk_i = ~clk_i;

  // Source ticks: oscillator every 2nd cycle, PLL every 4th, pin rises every 8th
  always @(posedge clk_i) begin
    tick_cnt <= tick_cnt + 3'h1;
    fast_osc_tick_i <= tick_cnt[0];
    pll_tick_i <= (tick_cnt[1:0] == 2'h3);
    ext_clk_i <= tick_cnt[2];
  end

  wtc_regs i_wtc_regs (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .fast_osc_tick_i(fast_osc_tick_i), .pll_tick_i(pll_tick_i), .ext_clk_i(ext_clk_i),
    .trig_a_i(trig_a_i), .trig_b_i(trig_b_i), .debug_halt_i(debug_halt_i),
    .key_written_i(key_written_i), .irq_o(irq_o), .core_clk_sel_o(core_clk_sel_o),
    .timer_run_o(timer_run_o), .count_o(count_o), .prog_event_o(prog_event_o),
    .fault_a_o(fault_a_o), .fault_b_o(fault_b_o)
  );

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] ex);
    n_checks++;
    if (seen !== ex) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", nm, ex, seen);
    end
  endtask

  // Classic single cycle, held until ack is sampled high
  task automatic wb(input logic we, input logic [5:0] idx, input logic [31:0] wd,
                    output logic [31:0] rd);
    int n;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= {idx, 2'h0};
    wb_sel_i <= 4'h3;
    wb_dat_i <= wd;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    if (n >= 20) begin
      err_count++;
      $display("wrong value bus ack expected 1 seen none");
    end
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask

  task automatic wr(input logic [5:0] idx, input logic [31:0] wd);
    logic [31:0] d;
    wb(1'b1, idx, wd, d);
  endtask

  task automatic rdc(input logic [5:0] idx, input logic [31:0] ex, input string nm);
    logic [31:0] d;
    wb(1'b0, idx, 32'h0, d);
    chk(nm, d, ex);
  endtask

  task automatic wait_run(input logic v);
    int n;
    n = 0;
    while (timer_run_o !== v && n < 200) begin
      @(posedge clk_i);
      n++;
    end
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk_i);
    err_count++;
    finish_test();
  end

  initial begin
    logic [11:0] c0;
    logic [11:0] diff;
    int lat [2];
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    rdc(IDX_CLK_EN_CTRL, 32'h00, "control reset");
    rdc(IDX_STATUS, 32'h03, "status reset");
    chk("irq reset", 32'(irq_o), 32'h0);
    foreach (rows[i]) begin
      wr(rows[i].idx, rows[i].wd);
      rdc(rows[i].idx, rows[i].ex, "row readback");
    end
    // Every clock source code reaches the core select
    for (int s = 0; s < 4; s++) begin
      wr(IDX_CLK_EN_CTRL, 32'(s << 5));
      repeat (2) @(posedge clk_i);
      chk("clock source", 32'(core_clk_sel_o), 32'(s));
    end
    // Enable crossing with slow synchronizer, disable refused meanwhile
    wr(IDX_CLK_EN_CTRL, 32'h67);
    rdc(IDX_STATUS, 32'h02, "status pending");
    chk("run early", 32'(timer_run_o), 32'h0);
    wr(IDX_CLK_EN_CTRL, 32'h66);
    wait_run(1'b1);
    chk("run late", 32'(timer_run_o), 32'h1);
    rdc(IDX_CLK_EN_CTRL, 32'h67, "refused change");
    rdc(IDX_STATUS, 32'h03, "status ready");
    wr(IDX_CLK_EN_CTRL, 32'h01);
    rdc(IDX_CLK_EN_CTRL, 32'h67, "locked fields");
    chk("source locked", 32'(core_clk_sel_o), 32'h3);
    wr(IDX_CLK_EN_CTRL, 32'h66);
    wait_run(1'b0);
    chk("run off", 32'(timer_run_o), 32'h0);
    // Counter prescaler codes over a 64 cycle span
    for (int c = 0; c < 4; c++) begin
      wr(IDX_CLK_EN_CTRL, 32'h61 | 32'(c << 3));
      wait_run(1'b1);
      repeat (2) @(posedge clk_i);
      c0 = count_o;
      repeat (64) @(posedge clk_i);
      diff = count_o - c0;
      chk("count steps", 32'(diff), cexp[c]);
      wr(IDX_CLK_EN_CTRL, 32'h60 | 32'(c << 3));
      wait_run(1'b0);
    end
    // Counting from the oscillator, PLL and pin clock sources over 64 cycles
    for (int s = 0; s < 3; s++) begin
      wr(IDX_CLK_EN_CTRL, 32'(s << 5) | 32'h01);
      wait_run(1'b1);
      c0 = count_o;
      repeat (64) @(posedge clk_i);
      diff = count_o - c0;
      chk("source steps", 32'(diff), sexp[s]);
      wr(IDX_CLK_EN_CTRL, 32'(s << 5));
      wait_run(1'b0);
    end
    // Delayed output event on trigger A
    wr(IDX_CLK_EN_CTRL, 32'h61);
    wait_run(1'b1);
    wr(IDX_DLY_CTRL, 32'h04);
    for (int k = 0; k < 2; k++) begin
      wr(IDX_DLY_CNT, 32'(k * 4));
      @(posedge clk_i);
      trig_a_i <= 1'b1;
      lat[k] = 0;
      do begin
        @(posedge clk_i);
        lat[k]++;
      end while (prog_event_o !== 1'b1 && lat[k] < 60);
      @(posedge clk_i);
      chk("event width", 32'(prog_event_o), 32'h0);
      trig_a_i <= 1'b0;
      repeat (8) @(posedge clk_i);
    end
    chk("event delay", 32'(lat[1] - lat[0]), 32'h4);
    // Sticky flag, masking and clearing
    rdc(IDX_IRQ_FLAGS, 32'h04, "trigger flag");
    chk("irq set", 32'(irq_o), 32'h1);
    wr(IDX_IRQ_EN, 32'h00);
    repeat (2) @(posedge clk_i);
    chk("irq masked", 32'(irq_o), 32'h0);
    wr(IDX_IRQ_EN, 32'h04);
    repeat (2) @(posedge clk_i);
    chk("irq unmasked", 32'(irq_o), 32'h1);
    wr(IDX_IRQ_FLAGS, 32'h04);
    repeat (2) @(posedge clk_i);
    chk("irq cleared", 32'(irq_o), 32'h0);
    rdc(IDX_IRQ_FLAGS, 32'h00, "flags cleared");
    trig_b_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    trig_b_i <= 1'b0;
    rdc(IDX_IRQ_FLAGS, 32'h08, "trigger b flag");
    // Debug halt faults on both channels, run bit keeps the counter going
    debug_halt_i <= 1'b1;
    c0 = count_o;
    repeat (3) @(posedge clk_i);
    chk("debug faults", 32'({fault_a_o, fault_b_o}), 32'h3);
    diff = count_o - c0;
    chk("debug run", 32'(diff), 32'h3);
    debug_halt_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    chk("debug faults end", 32'({fault_a_o, fault_b_o}), 32'h0);
    // Without the run bit a halt stops the counter
    wr(IDX_DBG_CTRL, 32'h00);
    debug_halt_i <= 1'b1;
    @(posedge clk_i);
    c0 = count_o;
    repeat (8) @(posedge clk_i);
    chk("debug stop", 32'(count_o), 32'(c0));
    chk("debug no fault", 32'({fault_a_o, fault_b_o}), 32'h0);
    debug_halt_i <= 1'b0;
    // Protected fault register
    wr(IDX_FAULT_CTRL, 32'hFF);
    rdc(IDX_FAULT_CTRL, 32'h00, "fault unkeyed");
    key_written_i <= 1'b1;
    @(posedge clk_i);
    key_written_i <= 1'b0;
    wr(IDX_FAULT_CTRL, 32'hFF);
    rdc(IDX_FAULT_CTRL, 32'hFF, "fault keyed");
    // Overflow at compare B clear value sets the overflow flag
    wr(IDX_CMP_B_CLR, 32'(count_o) + 32'h20);
    repeat (40) @(posedge clk_i);
    rdc(IDX_IRQ_FLAGS, 32'h09, "overflow flag");
    finish_test();
  end
endmodule

// File: wtc_pkg.sv
// Package of offsets, fields, masks and state type of the waveform timer register bank
package wtc_pkg;

  // Clock rate and protection window
  localparam int CLK_HZ = 50_000_000;
  localparam int KEY_WIN_INSNS = 4;
  localparam int CYC_PER_INSN = 1;
  localparam logic [2:0] KEY_WIN_CYC = 3'(KEY_WIN_INSNS * CYC_PER_INSN);

  // Register indices, byte address is four times the index
  localparam logic [5:0] IDX_CLK_EN_CTRL = 6'h00;
  localparam logic [5:0] IDX_WAVE_MODE = 6'h01;
  localparam logic [5:0] IDX_OUT_SEL = 6'h02;
  localparam logic [5:0] IDX_OVR_VAL = 6'h03;
  localparam logic [5:0] IDX_CMD_STROBE = 6'h04;
  localparam logic [5:0] IDX_IN_A_EVT = 6'h08;
  localparam logic [5:0] IDX_IN_B_EVT = 6'h09;
  localparam logic [5:0] IDX_IRQ_EN = 6'h0C;
  localparam logic [5:0] IDX_IRQ_FLAGS = 6'h0D;
  localparam logic [5:0] IDX_STATUS = 6'h0E;
  localparam logic [5:0] IDX_IN_A_MODE = 6'h10;
  localparam logic [5:0] IDX_IN_B_MODE = 6'h11;
  localparam logic [5:0] IDX_FAULT_CTRL = 6'h12;
  localparam logic [5:0] IDX_DLY_CTRL = 6'h14;
  localparam logic [5:0] IDX_DLY_CNT = 6'h15;
  localparam logic [5:0] IDX_DIT_CTRL = 6'h18;
  localparam logic [5:0] IDX_DIT_VAL = 6'h19;
  localparam logic [5:0] IDX_DBG_CTRL = 6'h1E;
  localparam logic [5:0] IDX_CAP_A = 6'h22;
  localparam logic [5:0] IDX_CAP_B = 6'h24;
  localparam logic [5:0] IDX_CMP_A_SET = 6'h28;
  localparam logic [5:0] IDX_CMP_A_CLR = 6'h2A;
  localparam logic [5:0] IDX_CMP_B_SET = 6'h2C;
  localparam logic [5:0] IDX_CMP_B_CLR = 6'h2E;

  // Writable bit masks
  localparam logic [7:0] MSK_CLK_EN = 8'h7F;
  localparam logic [7:0] MSK_WAVE = 8'h03;
  localparam logic [7:0] MSK_OUT_SEL = 8'hCB;
  localparam logic [7:0] MSK_CMD = 8'h9F;
  localparam logic [7:0] MSK_EVT = 8'hD5;
  localparam logic [7:0] MSK_IRQ = 8'h0D;
  localparam logic [7:0] MSK_IN_MODE = 8'h0F;
  localparam logic [7:0] MSK_DLY_CTRL = 8'h3F;
  localparam logic [7:0] MSK_DIT_CTRL = 8'h03;
  localparam logic [7:0] MSK_DIT_VAL = 8'h0F;
  localparam logic [7:0] MSK_DBG = 8'h05;

  // Field positions
  localparam int EN_BIT = 0;
  localparam int SYNC_LSB = 1;
  localparam int CNTP_LSB = 3;
  localparam int CSRC_LSB = 5;
  localparam int FLG_OVF = 0;
  localparam int FLG_TRIG_A = 2;
  localparam int FLG_TRIG_B = 3;
  localparam int DBG_RUN = 0;
  localparam int DBG_FAULT = 2;
  localparam int DLY_TRIG_LSB = 2;
  localparam int DLY_PRES_LSB = 4;

  // Clock source codes
  localparam logic [1:0] SRC_FAST_OSC = 2'h0;
  localparam logic [1:0] SRC_PLL = 2'h1;
  localparam logic [1:0] SRC_EXT = 2'h2;
  localparam logic [1:0] SRC_PERIPH = 2'h3;

  // Counter prescale masks, code 3 gives no tick
  localparam logic [4:0] CNT_MSK_DIVIDE_BY_ONE = 5'h00;
  localparam logic [4:0] CNT_MSK_DIV4 = 5'h03;
  localparam logic [4:0] CNT_MSK_DIVIDE_BY_THIRTY_TWO = 5'h1F;

  // Enable crossing ends on the synchronizer tick seen at this count, the second tick
  localparam logic [1:0] EN_SYNC_LAST = 2'h1;

  // Whole state of the register bank
  typedef struct packed {
    logic [6:0] clk_en;
    logic [7:0] wave, out_sel, ovr, cmd, evt_a, evt_b, irq_en, flags;
    logic [7:0] mode_a, mode_b, fault, dly_ctrl, dly_cnt, dit_ctrl, dit_val, dbg;
    logic [11:0] cap_a, cap_b, cmp_as, cmp_ac, cmp_bs, cmp_bc, cnt;
    logic ack;
    logic [31:0] dat;
    logic irq;
    logic en_pend;
    logic [1:0] en_sync;
    logic core_en;
    logic [2:0] sdiv, ddiv;
    logic [4:0] cdiv;
    logic [7:0] dwait;
    logic dact, progev;
    logic [2:0] key_win;
    logic flt_a, flt_b;
    logic [2:0] s1, s2, s3;
  } wtc_state_t;

endpackage

// File: wtc_regs.sv
// Waveform timer register bank with Wishbone slave and timer core tick logic
module wtc_regs
  import wtc_pkg::*;
(
  // System
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Clock source ticks and pin
  input wire logic fast_osc_tick_i,
  input wire logic pll_tick_i,
  input wire logic ext_clk_i,
  // Input events and system
  input wire logic trig_a_i,
  input wire logic trig_b_i,
  input wire logic debug_halt_i,
  input wire logic key_written_i,
  // Timer outputs
  output logic irq_o,
  output logic [1:0] core_clk_sel_o,
  output logic timer_run_o,
  output logic [11:0] count_o,
  output logic prog_event_o,
  output logic fault_a_o,
  output logic fault_b_o
);

  wtc_state_t st_r;
  wtc_state_t st_nxt;

  logic [2:0] edge_s;
  logic tmr_tick;
  logic [2:0] smask;
  logic [4:0] cmask;
  logic cnt_ok;
  logic [2:0] dmask;
  logic sync_tick;
  logic cnt_tick;
  logic dly_tick;
  logic running;
  logic ovf_ev;
  logic dly_trig;
  logic req;
  logic wr;
  logic wr0;
  logic wr1;
  logic [5:0] idx;
  logic [7:0] wb0;
  logic [11:0] w12;
  logic en_lock;
  logic [31:0] rd_val;
  logic [7:0] flag_set;
  logic [7:0] flag_clr;

  // Edges of synchronised pins, taken from second and third stage
  assign edge_s = st_r.s2 & ~st_r.s3;

  // Timer core clock source
  always_comb begin
    case (st_r.clk_en[CSRC_LSB+:2])
      SRC_FAST_OSC: tmr_tick = fast_osc_tick_i;
      SRC_PLL: tmr_tick = pll_tick_i;
      SRC_EXT: tmr_tick = edge_s[2];
      SRC_PERIPH: tmr_tick = 1'b1;
      default: tmr_tick = 1'b0;
    endcase
  end

  // Prescaler masks
  always_comb begin
    case (st_r.clk_en[SYNC_LSB+:2])
      2'h0: smask = 3'h0;
      2'h1: smask = 3'h1;
      2'h2: smask = 3'h3;
      default: smask = 3'h7;
    endcase
    cnt_ok = 1'b1;
    case (st_r.clk_en[CNTP_LSB+:2])
      2'h0: cmask = CNT_MSK_DIVIDE_BY_ONE;
      2'h1: cmask = CNT_MSK_DIV4;
      2'h2: cmask = CNT_MSK_DIVIDE_BY_THIRTY_TWO;
      default: begin
        cmask = CNT_MSK_DIVIDE_BY_ONE;
        cnt_ok = 1'b0;
      end
    endcase
    case (st_r.dly_ctrl[DLY_PRES_LSB+:2])
      2'h0: dmask = 3'h0;
      2'h1: dmask = 3'h1;
      2'h2: dmask = 3'h3;
      default: dmask = 3'h7;
    endcase
  end

  assign sync_tick = tmr_tick & ((st_r.sdiv & smask) == smask);
  assign cnt_tick = tmr_tick & cnt_ok & ((st_r.cdiv & cmask) == cmask);
  assign dly_tick = sync_tick & ((st_r.ddiv & dmask) == dmask);

  // Counter runs when enabled, unless halted without run-in-debug
  assign running = st_r.core_en & (~debug_halt_i | st_r.dbg[DBG_RUN]);
  assign ovf_ev = running & cnt_tick & (st_r.cnt == st_r.cmp_bc);

  // Delay trigger select
  always_comb begin
    case (st_r.dly_ctrl[DLY_TRIG_LSB+:2])
      2'h1: dly_trig = edge_s[0];
      2'h2: dly_trig = edge_s[1];
      default: dly_trig = ovf_ev;
    endcase
  end

  // Bus decode
  assign req = wb_cyc_i & wb_stb_i & ~st_r.ack;
  assign wr = req & wb_we_i;
  assign wr0 = wr & wb_sel_i[0];
  assign wr1 = wr & wb_sel_i[1];
  assign idx = wb_adr_i[7:2];
  assign wb0 = wb_dat_i[7:0];
  assign en_lock = st_r.clk_en[EN_BIT] | st_r.core_en;

  // Read mux, reserved offsets and bits give zero
  always_comb begin
    rd_val = 32'h0000_0000;
    case (idx)
      IDX_CLK_EN_CTRL: rd_val[6:0] = st_r.clk_en;
      IDX_WAVE_MODE: rd_val[7:0] = st_r.wave;
      IDX_OUT_SEL: rd_val[7:0] = st_r.out_sel;
      IDX_OVR_VAL: rd_val[7:0] = st_r.ovr;
      IDX_CMD_STROBE: rd_val[7:0] = st_r.cmd;
      IDX_IN_A_EVT: rd_val[7:0] = st_r.evt_a;
      IDX_IN_B_EVT: rd_val[7:0] = st_r.evt_b;
      IDX_IRQ_EN: rd_val[7:0] = st_r.irq_en;
      IDX_IRQ_FLAGS: rd_val[7:0] = st_r.flags;
      IDX_STATUS: rd_val[1:0] = {1'b1, ~st_r.en_pend};
      IDX_IN_A_MODE: rd_val[7:0] = st_r.mode_a;
      IDX_IN_B_MODE: rd_val[7:0] = st_r.mode_b;
      IDX_FAULT_CTRL: rd_val[7:0] = st_r.fault;
      IDX_DLY_CTRL: rd_val[7:0] = st_r.dly_ctrl;
      IDX_DLY_CNT: rd_val[7:0] = st_r.dly_cnt;
      IDX_DIT_CTRL: rd_val[7:0] = st_r.dit_ctrl;
      IDX_DIT_VAL: rd_val[7:0] = st_r.dit_val;
      IDX_DBG_CTRL: rd_val[7:0] = st_r.dbg;
      IDX_CAP_A: rd_val[11:0] = st_r.cap_a;
      IDX_CAP_B: rd_val[11:0] = st_r.cap_b;
      IDX_CMP_A_SET: rd_val[11:0] = st_r.cmp_as;
      IDX_CMP_A_CLR: rd_val[11:0] = st_r.cmp_ac;
      IDX_CMP_B_SET: rd_val[11:0] = st_r.cmp_bs;
      IDX_CMP_B_CLR: rd_val[11:0] = st_r.cmp_bc;
      default: rd_val = 32'h0000_0000;
    endcase
  end

  // Interrupt flag events and software clear
  always_comb begin
    flag_set = 8'h00;
    flag_set[FLG_OVF] = ovf_ev;
    flag_set[FLG_TRIG_A] = edge_s[0];
    flag_set[FLG_TRIG_B] = edge_s[1];
    flag_clr = (wr0 && idx == IDX_IRQ_FLAGS) ? (wb0 & MSK_IRQ) : 8'h00;
  end

  // 12-bit compare write, per byte lane
  always_comb begin
    w12 = 12'h000;
    case (idx)
      IDX_CMP_A_SET: w12 = st_r.cmp_as;
      IDX_CMP_A_CLR: w12 = st_r.cmp_ac;
      IDX_CMP_B_SET: w12 = st_r.cmp_bs;
      IDX_CMP_B_CLR: w12 = st_r.cmp_bc;
      default: w12 = 12'h000;
    endcase
    if (wr0) begin
      w12[7:0] = wb0;
    end
    if (wr1) begin
      w12[11:8] = wb_dat_i[11:8];
    end
  end

  // Next state
  always_comb begin
    st_nxt = st_r;
    st_nxt.s1 = {ext_clk_i, trig_b_i, trig_a_i};
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;

    // Wishbone answer one cycle after request
    st_nxt.ack = req;
    if (req) begin
      st_nxt.dat = rd_val;
    end

    // Sync and counter prescalers run freely on the timer tick, delay prescaler on the sync tick
    if (tmr_tick) begin
      st_nxt.sdiv = st_r.sdiv + 3'h1;
      st_nxt.cdiv = st_r.cdiv + 5'h01;
    end
    if (sync_tick) begin
      st_nxt.ddiv = st_r.ddiv + 3'h1;
    end

    // Register writes
    if (wr0) begin
      case (idx)
        IDX_CLK_EN_CTRL: begin
          if (!en_lock) begin
            st_nxt.clk_en[6:1] = wb0[6:1];
          end
          if (!st_r.en_pend && wb0[EN_BIT] != st_r.clk_en[EN_BIT]) begin
            st_nxt.clk_en[EN_BIT] = wb0[EN_BIT];
            st_nxt.en_pend = 1'b1;
            st_nxt.en_sync = 2'h0;
          end
        end
        IDX_WAVE_MODE: st_nxt.wave = wb0 & MSK_WAVE;
        IDX_OUT_SEL: st_nxt.out_sel = wb0 & MSK_OUT_SEL;
        IDX_OVR_VAL: st_nxt.ovr = wb0;
        IDX_CMD_STROBE: st_nxt.cmd = wb0 & MSK_CMD;
        IDX_IN_A_EVT: st_nxt.evt_a = wb0 & MSK_EVT;
        IDX_IN_B_EVT: st_nxt.evt_b = wb0 & MSK_EVT;
        IDX_IRQ_EN: st_nxt.irq_en = wb0 & MSK_IRQ;
        IDX_IN_A_MODE: st_nxt.mode_a = wb0 & MSK_IN_MODE;
        IDX_IN_B_MODE: st_nxt.mode_b = wb0 & MSK_IN_MODE;
        IDX_FAULT_CTRL: begin
          if (st_r.key_win != 3'h0) begin
            st_nxt.fault = wb0;
          end
        end
        IDX_DLY_CTRL: st_nxt.dly_ctrl = wb0 & MSK_DLY_CTRL;
        IDX_DLY_CNT: st_nxt.dly_cnt = wb0;
        IDX_DIT_CTRL: st_nxt.dit_ctrl = wb0 & MSK_DIT_CTRL;
        IDX_DIT_VAL: st_nxt.dit_val = wb0 & MSK_DIT_VAL;
        IDX_DBG_CTRL: st_nxt.dbg = wb0 & MSK_DBG;
        default: st_nxt.dat = st_nxt.dat;
      endcase
    end
    if (wr0 || wr1) begin
      case (idx)
        IDX_CMP_A_SET: st_nxt.cmp_as = w12;
        IDX_CMP_A_CLR: st_nxt.cmp_ac = w12;
        IDX_CMP_B_SET: st_nxt.cmp_bs = w12;
        IDX_CMP_B_CLR: st_nxt.cmp_bc = w12;
        default: st_nxt.dat = st_nxt.dat;
      endcase
    end

    // Protection window after key write
    if (key_written_i) begin
      st_nxt.key_win = KEY_WIN_CYC;
    end else if (st_r.key_win != 3'h0) begin
      st_nxt.key_win = st_r.key_win - 3'h1;
    end

    // Enable crossing on synchronizer ticks
    if (st_r.en_pend && sync_tick) begin
      st_nxt.en_sync = st_r.en_sync + 2'h1;
      if (st_r.en_sync == EN_SYNC_LAST) begin
        st_nxt.core_en = st_r.clk_en[EN_BIT];
        st_nxt.en_pend = 1'b0;
      end
    end

    // Counter
    if (running && cnt_tick) begin
      st_nxt.cnt = ovf_ev ? 12'h000 : st_r.cnt + 12'h001;
    end
    if (!st_r.core_en) begin
      st_nxt.cnt = 12'h000;
    end

    // Captures on input events
    if (edge_s[0]) begin
      st_nxt.cap_a = st_r.cnt;
    end
    if (edge_s[1]) begin
      st_nxt.cap_b = st_r.cnt;
    end

    // Flags, set wins over clear
    st_nxt.flags = (st_r.flags & ~flag_clr) | flag_set;
    st_nxt.irq = |(st_nxt.flags & st_nxt.irq_en);

    // Delayed programmable output event
    st_nxt.progev = 1'b0;
    if (st_r.dact) begin
      if (st_r.dwait == st_r.dly_cnt) begin
        st_nxt.progev = 1'b1;
        st_nxt.dact = 1'b0;
      end else if (dly_tick) begin
        st_nxt.dwait = st_r.dwait + 8'h01;
      end
    end else if (dly_trig) begin
      st_nxt.dact = 1'b1;
      st_nxt.dwait = 8'h00;
    end

    // Debug faults on both inputs while halted
    st_nxt.flt_a = debug_halt_i & st_r.dbg[DBG_FAULT];
    st_nxt.flt_b = debug_halt_i & st_r.dbg[DBG_FAULT];
  end

  // State register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_r <= '0;
    end else if (ce_i) begin
      st_r <= st_nxt;
    end
  end

  // Outputs straight from state
  assign wb_dat_o = st_r.dat;
  assign wb_ack_o = st_r.ack;
  assign irq_o = st_r.irq;
  assign core_clk_sel_o = st_r.clk_en[CSRC_LSB+:2];
  assign timer_run_o = st_r.core_en;
  assign count_o = st_r.cnt;
  assign prog_event_o = st_r.progev;
  assign fault_a_o = st_r.flt_a;
  assign fault_b_o = st_r.flt_b;

  // Checks
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  chk_clk_src_out: assert property (
    core_clk_sel_o == st_r.clk_en[6:5])
    else $error("clock select output differs from field");

  chk_cnt_tick_only: assert property (
    (ce_i && st_r.core_en && !cnt_tick && !rst_i) |=> $stable(count_o))
    else $error("counter moved without counter tick");

  chk_en_cross: assert property (
    (timer_run_o != st_r.clk_en[0]) |-> st_r.en_pend)
    else $error("enable mismatch without pending crossing");

  chk_en_refuse: assert property (
    (ce_i && wr0 && idx == IDX_CLK_EN_CTRL && st_r.en_pend)
      |=> (st_r.clk_en[0] == $past(st_r.clk_en[0])))
    else $error("enable changed while crossing pending");

  chk_field_lock: assert property (
    (ce_i && en_lock) |=> (st_r.clk_en[6:1] == $past(st_r.clk_en[6:1])))
    else $error("locked field changed while enabled");

  chk_reset_zero: assert property (
    disable iff (1'b0) ($past(rst_i) && !rst_i) |-> (st_r.clk_en == 7'h00 && !timer_run_o))
    else $error("control register not zero after reset");

  chk_irq_level: assert property (
    irq_o == |(st_r.flags & st_r.irq_en))
    else $error("interrupt level does not follow flags");

  chk_fault_key: assert property (
    (ce_i && st_r.key_win == 3'h0) |=> $stable(st_r.fault))
    else $error("fault control written without key");

  chk_debug_fault: assert property (
    (ce_i && debug_halt_i && st_r.dbg[2]) |=> (fault_a_o && fault_b_o))
    else $error("debug fault not raised on both inputs");

  chk_delay_zero: assert property (
    (ce_i && st_r.dact && st_r.dwait == st_r.dly_cnt) |=> prog_event_o)
    else $error("delayed event not issued at count");

  chk_reserved_rd: assert property (
    (ce_i && req && !wb_we_i && idx == 6'h05) |=> (wb_ack_o && wb_dat_o == 32'h0))
    else $error("reserved offset read not zero");

endmodule
